/* File: src/root_hub_global_status.sv */
// Behaviour
// - hub status sits in bits 15..0 and hub status change in bits 31..16.
// - writing one to bit 31 clears the wake enable; zero does nothing.
// - bit 17 is set on any change of the overcurrent bit and stays until software clears it.
// - bit 16 always reads zero.
// - in global mode writing one to bit 16 powers all ports; zero does nothing.
// - in per-port mode writing one to bit 16 powers only unmasked ports.
// - with wake enabled a connect change resumes a suspended bus and flags resume.
// - writing one to bit 15 sets the wake enable; zero leaves it.
// - bit 1 shows global overcurrent, or zero with per-port protection.
// - bit 0 always reads zero.
// - in global mode writing one to bit 0 unpowers all ports; zero does nothing.
// - in per-port mode writing one to bit 0 unpowers only unmasked ports.
// - mode zero powers ports together, mode one powers them individually.
// - in per-port mode masked ports obey only per-port commands, unmasked ports obey global ones.
`default_nettype none
module root_hub_global_status
    import rhgs_pkg::*;
#(
    parameter int NPORTS = 2
) (
    input  wire logic              CORE_CLK,
    input  wire logic              RST,
    input  wire logic              REG_WR,
    input  wire logic              REG_RD,
    input  wire logic [7:0]        REG_ADDR,
    input  wire logic [31:0]       REG_WDATA,
    output logic      [31:0]       REG_RDATA,
    input  wire logic              POWER_SWITCH_MODE,
    input  wire logic              PER_PORT_OC_PROT,
    input  wire logic [NPORTS-1:0] PORT_POWER_MASK_BITS,
    input  wire logic [NPORTS-1:0] PORT_POWER_SET,
    input  wire logic [NPORTS-1:0] PORT_POWER_CLR,
    input  wire logic              OVERCURRENT_PIN,
    input  wire logic              CONNECT_CHANGE_FLAG,
    input  wire logic              BUS_SUSPENDED_STATE,
    output logic      [NPORTS-1:0] PORT_POWER_STATUS,
    output logic                   BUS_RESUMING_STATE,
    output logic                   RESUME_DETECTED
);
    initial begin
        if (NPORTS < 1 || NPORTS > 15) begin
            $error("NPORTS must lie in 1..15");
        end
    end

    logic              device_wake_enable_ff;
    logic              global_overcurrent_flag_ff;
    logic              overcurrent_change_flag_ff;
    logic              resume_ff;
    logic [31:0]       rdata_ff;
    logic              oc_sync;
    logic              nxt_oc;
    logic              nxt_oc_chg;
    logic              nxt_wake;
    logic              nxt_resume;
    logic              hit_wr;
    logic              hit_rd;
    logic              wake_enable_clear_strobe;
    logic              wake_enable_set_strobe;
    logic              local_power_change_set_global;
    logic              local_power_clear_global;
    logic              oc_chg_clear_strobe;
    logic              resume_event;
    logic [31:0]       status_word;

    rhgs_sync u_oc_sync (
        .clk   (CORE_CLK),
        .rst   (RST),
        .d_in  (OVERCURRENT_PIN),
        .q_out (oc_sync)
    );

    // reserved write bits are ignored; software is expected to keep them zero
    assign hit_wr = REG_WR && (REG_ADDR == RHGS_OFFSET);
    assign hit_rd = REG_RD && (REG_ADDR == RHGS_OFFSET);
    assign wake_enable_clear_strobe      = hit_wr && REG_WDATA[RHGS_BIT_WAKE_CLR];
    assign wake_enable_set_strobe        = hit_wr && REG_WDATA[RHGS_BIT_WAKE];
    assign local_power_change_set_global = hit_wr && REG_WDATA[RHGS_BIT_SET_PWR];
    assign local_power_clear_global      = hit_wr && REG_WDATA[RHGS_BIT_CLR_PWR];
    assign oc_chg_clear_strobe           = hit_wr && REG_WDATA[RHGS_BIT_OC_CHG];

    // per-port protection forces the global indicator to zero
    assign nxt_oc     = PER_PORT_OC_PROT ? 1'b0 : oc_sync;
    // a change in the same cycle as the clear wins, so no change is lost
    assign nxt_oc_chg = (nxt_oc != global_overcurrent_flag_ff) ? 1'b1 :
                        (oc_chg_clear_strobe ? 1'b0 : overcurrent_change_flag_ff);
    // set and clear in one write: the clear is applied last
    assign nxt_wake   = wake_enable_clear_strobe ? 1'b0 :
                        (wake_enable_set_strobe ? 1'b1 : device_wake_enable_ff);
    assign resume_event = device_wake_enable_ff && CONNECT_CHANGE_FLAG
                          && BUS_SUSPENDED_STATE;
    assign nxt_resume   = resume_event;

    assign status_word = {wake_enable_clear_strobe & 1'b0, 13'h0000,
                          overcurrent_change_flag_ff, 1'b0,
                          device_wake_enable_ff, 13'h0000,
                          global_overcurrent_flag_ff, 1'b0};

    always_ff @(posedge CORE_CLK or posedge RST) begin
        if (RST) begin
            device_wake_enable_ff      <= RHGS_RESET[RHGS_BIT_WAKE];
            global_overcurrent_flag_ff <= RHGS_RESET[RHGS_BIT_OC];
            overcurrent_change_flag_ff <= RHGS_RESET[RHGS_BIT_OC_CHG];
            resume_ff                  <= 1'b0;
            rdata_ff                   <= RHGS_RESET;
        end else begin
            device_wake_enable_ff      <= nxt_wake;
            global_overcurrent_flag_ff <= nxt_oc;
            overcurrent_change_flag_ff <= nxt_oc_chg;
            resume_ff                  <= nxt_resume;
            rdata_ff                   <= hit_rd ? status_word : 32'h0000_0000;
        end
    end

    rhgs_port_power #(
        .NPORTS (NPORTS)
    ) u_power (
        .clk      (CORE_CLK),
        .rst      (RST),
        .mode     (POWER_SWITCH_MODE),
        .mask     (PORT_POWER_MASK_BITS),
        .set_all  (local_power_change_set_global),
        .clr_all  (local_power_clear_global),
        .port_set (PORT_POWER_SET),
        .port_clr (PORT_POWER_CLR),
        .power_ff (PORT_POWER_STATUS)
    );

    assign REG_RDATA          = rdata_ff;
    assign BUS_RESUMING_STATE = resume_ff;
    assign RESUME_DETECTED    = resume_ff;

    AST_WAKE_CLR: assert property (@(posedge CORE_CLK) disable iff (RST)
        wake_enable_clear_strobe |=> !device_wake_enable_ff)
        else $error("wake enable not cleared");
    AST_WAKE_SET: assert property (@(posedge CORE_CLK) disable iff (RST)
        (wake_enable_set_strobe && !wake_enable_clear_strobe) |=> device_wake_enable_ff)
        else $error("wake enable not set");
    AST_WAKE_HOLD: assert property (@(posedge CORE_CLK) disable iff (RST)
        !hit_wr |=> $stable(device_wake_enable_ff))
        else $error("wake enable moved without write");
    AST_OC_CHG: assert property (@(posedge CORE_CLK) disable iff (RST)
        $changed(global_overcurrent_flag_ff) |-> overcurrent_change_flag_ff)
        else $error("overcurrent change not flagged");
    AST_OC_STICKY: assert property (@(posedge CORE_CLK) disable iff (RST)
        (overcurrent_change_flag_ff && !oc_chg_clear_strobe) |=> overcurrent_change_flag_ff)
        else $error("overcurrent change lost");
    AST_OC_PERPORT: assert property (@(posedge CORE_CLK) disable iff (RST)
        PER_PORT_OC_PROT |=> !global_overcurrent_flag_ff)
        else $error("overcurrent shown under per-port protection");
    AST_RD_ZERO: assert property (@(posedge CORE_CLK) disable iff (RST)
        hit_rd |=> (REG_RDATA[RHGS_BIT_SET_PWR] == 1'b0 && REG_RDATA[RHGS_BIT_CLR_PWR] == 1'b0))
        else $error("local power bits read nonzero");
    AST_RD_WAKE: assert property (@(posedge CORE_CLK) disable iff (RST)
        hit_rd |=> REG_RDATA[RHGS_BIT_WAKE] == $past(device_wake_enable_ff))
        else $error("wake enable read wrong");
    AST_RESUME: assert property (@(posedge CORE_CLK) disable iff (RST)
        (device_wake_enable_ff && CONNECT_CHANGE_FLAG && BUS_SUSPENDED_STATE)
        |=> (BUS_RESUMING_STATE && RESUME_DETECTED))
        else $error("resume not raised");
    AST_NO_RESUME: assert property (@(posedge CORE_CLK) disable iff (RST)
        !device_wake_enable_ff |=> !RESUME_DETECTED)
        else $error("resume without wake enable");
    AST_GLOBAL_ON: assert property (@(posedge CORE_CLK) disable iff (RST)
        (local_power_change_set_global && !local_power_clear_global
         && POWER_SWITCH_MODE == RHGS_MODE_GLOBAL && PORT_POWER_CLR == '0)
        |=> PORT_POWER_STATUS == {NPORTS{1'b1}})
        else $error("global power on failed");
    AST_GLOBAL_OFF: assert property (@(posedge CORE_CLK) disable iff (RST)
        (local_power_clear_global && POWER_SWITCH_MODE == RHGS_MODE_GLOBAL)
        |=> PORT_POWER_STATUS == '0)
        else $error("global power off failed");
    AST_MASKED_KEEP: assert property (@(posedge CORE_CLK) disable iff (RST)
        (POWER_SWITCH_MODE == RHGS_MODE_PORT && PORT_POWER_SET == '0 && PORT_POWER_CLR == '0)
        |=> ((PORT_POWER_STATUS & $past(PORT_POWER_MASK_BITS))
             == ($past(PORT_POWER_STATUS) & $past(PORT_POWER_MASK_BITS))))
        else $error("masked port followed global command");
    AST_PORT_ON: assert property (@(posedge CORE_CLK) disable iff (RST)
        (local_power_change_set_global && !local_power_clear_global
         && POWER_SWITCH_MODE == RHGS_MODE_PORT)
        |=> ((PORT_POWER_STATUS & ~$past(PORT_POWER_MASK_BITS)) == ~$past(PORT_POWER_MASK_BITS)))
        else $error("unmasked port not powered");
    AST_PORT_OFF: assert property (@(posedge CORE_CLK) disable iff (RST)
        (local_power_clear_global && POWER_SWITCH_MODE == RHGS_MODE_PORT)
        |=> ((PORT_POWER_STATUS & ~$past(PORT_POWER_MASK_BITS)) == '0))
        else $error("unmasked port not unpowered");
endmodule : root_hub_global_status
`default_nettype wire

/* File: src/rhgs_pkg.sv */
`default_nettype none
package rhgs_pkg;
    localparam logic [7:0]  RHGS_OFFSET       = 8'h50;
    localparam int          RHGS_BIT_CLR_PWR  = 0;
    localparam int          RHGS_BIT_OC       = 1;
    localparam int          RHGS_BIT_WAKE     = 15;
    localparam int          RHGS_BIT_SET_PWR  = 16;
    localparam int          RHGS_BIT_OC_CHG   = 17;
    localparam int          RHGS_BIT_WAKE_CLR = 31;
    localparam logic [31:0] RHGS_RESET        = 32'h0000_0000;
    localparam logic        RHGS_MODE_GLOBAL  = 1'b0;
    localparam logic        RHGS_MODE_PORT    = 1'b1;
endpackage : rhgs_pkg
`default_nettype wire

/* File: src/rhgs_sync.sv */
`default_nettype none
module rhgs_sync (
    input  wire logic clk,
    input  wire logic rst,
    input  wire logic d_in,
    output logic      q_out
);
    logic meta_ff;
    // first stage is read only by the second
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            meta_ff <= 1'b0;
            q_out   <= 1'b0;
        end else begin
            meta_ff <= d_in;
            q_out   <= meta_ff;
        end
    end
endmodule : rhgs_sync
`default_nettype wire

/* File: src/rhgs_port_power.sv */
`default_nettype none
module rhgs_port_power
    import rhgs_pkg::*;
#(
    parameter int NPORTS = 2
) (
    input  wire logic              clk,
    input  wire logic              rst,
    input  wire logic              mode,
    input  wire logic [NPORTS-1:0] mask,
    input  wire logic              set_all,
    input  wire logic              clr_all,
    input  wire logic [NPORTS-1:0] port_set,
    input  wire logic [NPORTS-1:0] port_clr,
    output logic      [NPORTS-1:0] power_ff
);
    logic [NPORTS-1:0] global_sel;
    logic [NPORTS-1:0] port_sel;
    logic [NPORTS-1:0] nxt_power;
    // global mode: every port follows global commands; per-port: only unmasked ones
    assign global_sel = (mode == RHGS_MODE_GLOBAL) ? {NPORTS{1'b1}} : ~mask;
    assign port_sel   = (mode == RHGS_MODE_PORT) ? mask : {NPORTS{1'b0}};
    // clear beats set on the same cycle so a power-off request is never lost
    assign nxt_power  = ((power_ff | (global_sel & {NPORTS{set_all}}) | (port_sel & port_set))
                        & ~(global_sel & {NPORTS{clr_all}}) & ~(port_sel & port_clr));
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            power_ff <= '0;
        end else begin
            power_ff <= nxt_power;
        end
    end
endmodule : rhgs_port_power
`default_nettype wire

/* File: bench/rhgs_driver_model.sv */
`default_nettype none
module rhgs_driver_model (
    input  wire logic        clk,
    output logic             wr,
    output logic             rd,
    output logic [7:0]       addr,
    output logic [31:0]      wdata,
    input  wire logic [31:0] rdata
);
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [31:0] IMPL = 32'h8003_8003;
    initial {wr, rd, addr, wdata} = '0;
    task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        wr    <= 1'b1;
        addr  <= a;
        wdata <= d & IMPL;
        @(posedge clk);
        wr    <= 1'b0;
        // released bus shows garbage, not the last word
        wdata <= ~(d & IMPL);
    endtask : wr_reg
    task automatic rd_reg(input logic [7:0] a, output logic [31:0] d);
        @(posedge clk);
        rd   <= 1'b1;
        addr <= a;
        @(posedge clk);
        rd <= 1'b0;
        #1 d = rdata;
    endtask : rd_reg
endmodule : rhgs_driver_model
`default_nettype wire

/* File: bench/root_hub_global_status_test.sv */
`default_nettype none
`define CHK(nm, e, s) begin n_checks++; if ((s) !== (e)) begin n_fail++; \
    $display("[ERR] %s exp %0h got %0h", nm, e, s); end end
module root_hub_global_status_test;
    import rhgs_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int NP = 3;
    logic clk = 0, rst = 1, wr, rd, mode = 0, prot = 0, oc = 0, conn = 0, susp = 0, res, det;
    logic [7:0] addr;
    logic [31:0] wd, rdat, d;
    logic [NP-1:0] mask = '0, pset = '0, pclr = '0, pwr, pw, s, c;
    logic wake, occ, global_overcurrent_flag;
    int n_fail = 0, n_checks = 0;
    rhgs_driver_model rhgs_driver_model_i (.clk(clk), .wr(wr), .rd(rd), .addr(addr),
        .wdata(wd), .rdata(rdat));
    root_hub_global_status #(.NPORTS(NP)) root_hub_global_status_i (.CORE_CLK(clk), .RST(rst),
        .REG_WR(wr), .REG_RD(rd), .REG_ADDR(addr), .REG_WDATA(wd), .REG_RDATA(rdat),
        .POWER_SWITCH_MODE(mode), .PER_PORT_OC_PROT(prot), .PORT_POWER_MASK_BITS(mask),
        .PORT_POWER_SET(pset), .PORT_POWER_CLR(pclr), .OVERCURRENT_PIN(oc),
        .CONNECT_CHANGE_FLAG(conn), .BUS_SUSPENDED_STATE(susp), .PORT_POWER_STATUS(pwr),
        .BUS_RESUMING_STATE(res), .RESUME_DETECTED(det));
    initial forever #2 clk = ~clk;
    task automatic results;
        $display("checks %0d fails %0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : results
    task automatic w(input logic [31:0] v);
        rhgs_driver_model_i.wr_reg(RHGS_OFFSET, v);
    endtask : w
    task automatic chk_rd;
        rhgs_driver_model_i.rd_reg(RHGS_OFFSET, d);
        `CHK("status", {14'h0, occ, 1'b0, wake, 13'h0, global_overcurrent_flag & ~prot, 1'b0}, d)
    endtask : chk_rd
    task automatic chk_pw;
        #1 `CHK("power", pw, pwr)
    endtask : chk_pw
    initial begin
        #20000;
        n_fail++;
        results();
    end
    initial begin
        void'($urandom(74416));
        {wake, occ, global_overcurrent_flag, pw} = '0;
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        chk_pw();
        chk_rd();
        w(32'h0000_8000);
        wake = 1;
        chk_rd();
        w(32'h0000_0000);
        chk_rd();
        for (int k = 0; k < 2; k++) begin
            w(k ? 32'h0000_8000 : 32'h8000_0000);
            wake = k[0];
            chk_rd();
            @(posedge clk);
            conn <= 1'b1;
            susp <= 1'b1;
            @(posedge clk);
            conn <= 1'b0;
            #1 `CHK("resuming", k[0], res)
            `CHK("resume_irq", k[0], det)
        end
        oc <= 1'b1;
        repeat (5) @(posedge clk);
        {global_overcurrent_flag, occ} = 2'b11;
        chk_rd();
        w(32'h0002_0000);
        occ = 0;
        chk_rd();
        prot <= 1'b1;
        oc <= 1'b0;
        repeat (5) @(posedge clk);
        oc <= 1'b1;
        repeat (5) @(posedge clk);
        rhgs_driver_model_i.rd_reg(RHGS_OFFSET, d);
        `CHK("oc_bit", 1'b0, d[1])
        prot <= 1'b0;
        oc <= 1'b0;
        repeat (5) @(posedge clk);
        w(32'h0002_0000);
        {global_overcurrent_flag, occ} = 2'b00;
        chk_rd();
        w(32'h0001_0000);
        pw = '1;
        chk_pw();
        chk_rd();
        w(32'h0000_0001);
        pw = '0;
        chk_pw();
        chk_rd();
        mode <= 1'b1;
        // random masks so both masked and unmasked ports see every command
        repeat (6) begin
            mask <= NP'($urandom);
            w(32'h0001_0000);
            pw = pw | ~mask;
            chk_pw();
            s = NP'($urandom);
            c = NP'($urandom);
            pset <= s;
            pclr <= c;
            @(posedge clk);
            {pset, pclr} <= '0;
            pw = (pw | (s & mask)) & ~(c & mask);
            chk_pw();
            w(32'h0000_0001);
            pw = pw & mask;
            chk_pw();
        end
        rhgs_driver_model_i.wr_reg(8'h54, 32'h8000_0000);
        chk_rd();
        rhgs_driver_model_i.rd_reg(8'h54, d);
        `CHK("unmapped", 32'h0000_0000, d)
        results();
    end
endmodule : root_hub_global_status_test
`default_nettype wire
